/* core/ifte_pkg.sv */
// Purpose: Constants and types for the instruction fault and trace exception unit.
// Assumes: 32-bit addresses, 16-bit status word with trace field in bits 15..14.
// Notes:   Shared by the core module and the bench.
// Functional notes
// - Illegal or unimplemented instructions are never executed; exception processing replaces them.
// - Entry copies status word, sets supervisor, clears both trace bits.
// - Vector 4 for illegal, vector 10 for unimplemented instruction.
// - Frame holds offset, status copy, and offending instruction address.
// - Privileged instruction in user mode raises a privilege violation.
// - Privilege violation caught before execution; supervisor, trace cleared, vector 8.
// - Privilege frame program counter is the violating instruction's first word.
// - After any exception, prefetch from fetched vector address, then resume.
// - Trace field: 00 none, 01 change of flow, 10 every instruction, 11 reserved.
// - Trace field sampled at instruction start decides its trace.
// - Change-of-flow mode traces only flow redirections and status word writes.
// - Trace taken after completion; instruction complete only after trace processing.
// - Suspended traced instruction defers trace until resumed and completed.
// - Pending interrupt waits until trace exception processing is done.
// - Forced exception of an instruction is processed before its trace.
// - Illegal or unimplemented instruction never produces a trace exception.
// - Trace between instructions; supervisor, trace bits cleared, vector 9.
// - Trace frame program counter is the next instruction's address.
// - Stop starting with trace field 3 loads status, traces, never stops.
// - Opword bits 15..12 equal to hex A means unimplemented instruction.
// - Vector addresses are relative to a programmable vector base register.
package ifte_pkg;

  // Register offsets (byte addresses).
  localparam logic [3:0] IFTE_OFS_VBASE   = 4'h0;
  localparam logic [3:0] IFTE_OFS_INFO    = 4'h4;
  localparam logic [3:0] IFTE_OFS_PC      = 4'h8;
  localparam logic [3:0] IFTE_OFS_COUNT   = 4'hc;
  localparam logic [31:0] IFTE_VBASE_RST  = 32'h0000_0000;

  // Status word fields.
  localparam int IFTE_SR_TUP  = 15;
  localparam int IFTE_SR_TLO  = 14;
  localparam int IFTE_SR_SUP  = 13;

  // Vector numbers.
  localparam logic [7:0] IFTE_VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] IFTE_VEC_PRIV    = 8'h08;
  localparam logic [7:0] IFTE_VEC_TRACE   = 8'h09;
  localparam logic [7:0] IFTE_VEC_UNIMPL  = 8'h0a;
  localparam logic [3:0] IFTE_ALINE       = 4'ha;

  // Trace field encodings.
  localparam logic [1:0] IFTE_TR_NONE = 2'h0;
  localparam logic [1:0] IFTE_TR_FLOW = 2'h1;
  localparam logic [1:0] IFTE_TR_ALL  = 2'h2;
  localparam logic [1:0] IFTE_TR_RSVD = 2'h3;

  typedef enum logic [1:0] {
    IFTE_IDLE,
    IFTE_FRAME,
    IFTE_VFETCH,
    IFTE_PREF
  } ifte_state_t;

  // Stack frame handed to the stacking logic.
  typedef struct packed {
    logic [7:0]  vec;
    logic [15:0] offset;
    logic [31:0] pc;
    logic [15:0] sr;
  } ifte_frame_t;

  // Instruction as it begins execution.
  typedef struct packed {
    logic        valid;
    logic [15:0] opword;
    logic [31:0] pc;
    logic        illegal;
    logic        priv;
    logic        flow;
    logic        stop;
  } ifte_issue_t;

  // Instruction completion report.
  typedef struct packed {
    logic        valid;
    logic [31:0] next_pc;
    logic        flow_taken;
    logic        forced;
    logic [7:0]  forced_vec;
    logic [31:0] forced_pc;
  } ifte_done_t;

endpackage : ifte_pkg

/* core/ifte_core.sv */
// Purpose: Sequences illegal, unimplemented, privilege and trace exceptions.
// Assumes: Pipeline reports issue and completion; inputs synchronous to core_clk_i.
// Notes:   All outputs are registered; registers reached over a plain strobe port.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module ifte_core (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  // Register port
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // Pipeline events
  input  wire ifte_pkg::ifte_issue_t issue_i,
  input  wire ifte_pkg::ifte_done_t  done_i,
  input  wire logic                  suspend_i,
  input  wire logic                  irq_pending_i,
  input  wire logic [15:0]           status_word_i,
  // Status word update and execution control
  output logic                       sr_wr_o,
  output logic      [15:0]           sr_new_o,
  output logic                       exec_block_o,
  output logic                       stop_inhibit_o,
  output logic                       irq_hold_o,
  output logic                       busy_o,
  // Frame stacking
  output logic                       frame_req_o,
  output ifte_pkg::ifte_frame_t      frame_o,
  input  wire logic                  frame_ack_i,
  // Vector fetch and prefetch
  output logic                       vec_rd_o,
  output logic      [31:0]           vec_addr_o,
  input  wire logic                  vec_valid_i,
  input  wire logic [31:0]           vec_data_i,
  output logic                       fetch_req_o,
  output logic      [31:0]           fetch_addr_o,
  input  wire logic                  fetch_ack_i
);
  import ifte_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ifte_state_t fsm;
    logic [31:0] vbase;
    logic        busy;
    logic        inflight;
    logic        suspended;
    logic [1:0]  tmode;
    logic        tflow;
    logic        tstop;
    logic        tpend;
    logic [31:0] tpc;
    logic [31:0] count;
    logic [31:0] rdata;
    logic        sr_wr;
    logic [15:0] sr_new;
    logic        exec_block;
    logic        stop_inh;
    logic        irq_hold;
    logic        frame_req;
    ifte_frame_t frame;
    logic        vec_rd;
    logic [31:0] vec_addr;
    logic        fetch_req;
    logic [31:0] fetch_addr;
  } ifte_regs_t;

  ifte_regs_t st_r;
  ifte_regs_t st_nxt;

  // Frame with status copy; offset is vector times four.
  function automatic ifte_frame_t mk_frame(input logic [7:0] vec, input logic [31:0] pc,
                                            input logic [15:0] sr);
    ifte_frame_t f;
    f.vec    = vec;
    f.offset = {6'h00, vec, 2'h0};
    f.pc     = pc;
    f.sr     = sr;
    return f;
  endfunction : mk_frame

  // Supervisor set, both trace bits cleared.
  function automatic logic [15:0] entry_sr(input logic [15:0] sr);
    logic [15:0] s;
    s              = sr;
    s[IFTE_SR_SUP] = 1'b1;
    s[IFTE_SR_TUP] = 1'b0;
    s[IFTE_SR_TLO] = 1'b0;
    return s;
  endfunction : entry_sr

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic        take;
    logic [7:0]  tvec;
    logic [31:0] tpc;
    logic        trace_now;
    st_nxt    = st_r;
    take      = 1'b0;
    tvec      = 8'h00;
    tpc       = 32'h0000_0000;
    trace_now = 1'b0;
    st_nxt.sr_wr      = 1'b0;
    st_nxt.exec_block = 1'b0;

    // Register port.
    if (reg_wr_i) begin
      if (reg_addr_i == IFTE_OFS_VBASE) begin
        st_nxt.vbase = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == IFTE_OFS_VBASE) begin
        st_nxt.rdata = st_r.vbase;
      end else if (reg_addr_i == IFTE_OFS_INFO) begin
        st_nxt.rdata = {st_r.frame.sr, 6'h00, st_r.fsm, st_r.frame.vec};
      end else if (reg_addr_i == IFTE_OFS_PC) begin
        st_nxt.rdata = st_r.frame.pc;
      end else if (reg_addr_i == IFTE_OFS_COUNT) begin
        st_nxt.rdata = st_r.count;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end

    case (st_r.fsm)
      IFTE_IDLE: begin
        if (st_r.tpend) begin
          // Trace left over after a forced exception.
          take         = 1'b1;
          tvec         = IFTE_VEC_TRACE;
          tpc          = st_r.tpc;
          st_nxt.tpend = 1'b0;
        end else if (issue_i.valid && !(st_r.inflight && st_r.suspended)) begin
          if (issue_i.opword[15:12] == IFTE_ALINE) begin
            take              = 1'b1;
            tvec              = IFTE_VEC_UNIMPL;
            tpc               = issue_i.pc;
            st_nxt.exec_block = 1'b1;
          end else if (issue_i.illegal) begin
            take              = 1'b1;
            tvec              = IFTE_VEC_ILLEGAL;
            tpc               = issue_i.pc;
            st_nxt.exec_block = 1'b1;
          end else if (issue_i.priv && !status_word_i[IFTE_SR_SUP]) begin
            take              = 1'b1;
            tvec              = IFTE_VEC_PRIV;
            tpc               = issue_i.pc;
            st_nxt.exec_block = 1'b1;
          end else begin
            // Trace field taken as execution begins.
            st_nxt.inflight  = 1'b1;
            st_nxt.suspended = 1'b0;
            st_nxt.tmode     = status_word_i[IFTE_SR_TUP:IFTE_SR_TLO];
            st_nxt.tflow     = issue_i.flow;
            st_nxt.tstop     = issue_i.stop;
            st_nxt.stop_inh  = issue_i.stop &&
                               (status_word_i[IFTE_SR_TUP:IFTE_SR_TLO] == IFTE_TR_RSVD);
          end
        end
        if (!take && st_r.inflight && done_i.valid) begin
          case (st_r.tmode)
            IFTE_TR_NONE: trace_now = 1'b0;
            IFTE_TR_FLOW: trace_now = st_r.tflow && done_i.flow_taken;
            IFTE_TR_ALL:  trace_now = 1'b1;
            default:      trace_now = st_r.tstop;
          endcase
          st_nxt.inflight  = 1'b0;
          st_nxt.suspended = 1'b0;
          st_nxt.stop_inh  = 1'b0;
          if (done_i.forced) begin
            take         = 1'b1;
            tvec         = done_i.forced_vec;
            tpc          = done_i.forced_pc;
            st_nxt.tpend = trace_now;
            st_nxt.tpc   = done_i.next_pc;
          end else if (trace_now) begin
            take = 1'b1;
            tvec = IFTE_VEC_TRACE;
            tpc  = done_i.next_pc;
          end
        end
        // A suspension reported in the completing cycle wins over the clear when no exception or trace is taken.
        if (!take && st_r.inflight && suspend_i) begin
          st_nxt.suspended = 1'b1;
        end
        if (take) begin
          st_nxt.frame     = mk_frame(tvec, tpc, status_word_i);
          st_nxt.sr_new    = entry_sr(status_word_i);
          st_nxt.sr_wr     = 1'b1;
          st_nxt.frame_req = 1'b1;
          st_nxt.count     = st_r.count + 32'h0000_0001;
          st_nxt.fsm       = IFTE_FRAME;
        end
      end
      IFTE_FRAME: begin
        if (frame_ack_i) begin
          st_nxt.frame_req = 1'b0;
          st_nxt.vec_rd    = 1'b1;
          st_nxt.vec_addr  = st_r.vbase + {16'h0000, st_r.frame.offset};
          st_nxt.fsm       = IFTE_VFETCH;
        end
      end
      IFTE_VFETCH: begin
        if (vec_valid_i) begin
          st_nxt.vec_rd     = 1'b0;
          st_nxt.fetch_req  = 1'b1;
          st_nxt.fetch_addr = vec_data_i;
          st_nxt.fsm        = IFTE_PREF;
        end
      end
      IFTE_PREF: begin
        if (fetch_ack_i) begin
          st_nxt.fetch_req = 1'b0;
          st_nxt.fsm       = IFTE_IDLE;
        end
      end
      default: st_nxt.fsm = IFTE_IDLE;
    endcase

    // Interrupts wait while a trace is owed or being processed.
    st_nxt.irq_hold = irq_pending_i && (st_nxt.tpend || (take && tvec == IFTE_VEC_TRACE) ||
                      (st_nxt.fsm != IFTE_IDLE && st_nxt.frame.vec == IFTE_VEC_TRACE));
    st_nxt.busy = st_nxt.frame_req | st_nxt.vec_rd | st_nxt.fetch_req | st_nxt.tpend;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r     <= '0;
      st_r.fsm <= IFTE_IDLE;
      st_r.vbase <= IFTE_VBASE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o    = st_r.rdata;
  assign sr_wr_o        = st_r.sr_wr;
  assign sr_new_o       = st_r.sr_new;
  assign exec_block_o   = st_r.exec_block;
  assign stop_inhibit_o = st_r.stop_inh;
  assign irq_hold_o     = st_r.irq_hold;
  assign busy_o         = st_r.busy;
  assign frame_req_o    = st_r.frame_req;
  assign frame_o        = st_r.frame;
  assign vec_rd_o       = st_r.vec_rd;
  assign vec_addr_o     = st_r.vec_addr;
  assign fetch_req_o    = st_r.fetch_req;
  assign fetch_addr_o   = st_r.fetch_addr;

endmodule : ifte_core

/* sim/ifte_pipe_model.sv */
// Purpose: Pipeline side model that acknowledges frame requests and serves vector and prefetch reads.
// Assumes: The unit keeps at most one request open at a time.
// Notes:   The vector data toggles every cycle while no vector is returned.
`timescale 1ns/1ps
module ifte_pipe_model #(
  parameter logic [31:0] HANDLER = 32'h0000_2000
) (
  // Clock, reset and pacing
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        slow_i,
  // Requests from the unit
  input  wire logic        frame_req_i,
  input  wire logic        vec_rd_i,
  input  wire logic        fetch_req_i,
  // Answers
  output logic             frame_ack_o,
  output logic             vec_valid_o,
  output logic             fetch_ack_o,
  output logic      [31:0] vec_data_o
);
  logic [1:0] wait_r;
  logic       open;
  logic       go;
  // A request stays open until the cycle after its answer, so it is answered once.
  assign open = (frame_req_i && !frame_ack_o) || (vec_rd_i && !vec_valid_o) ||
                (fetch_req_i && !fetch_ack_o);
  assign go   = open && (wait_r == {slow_i, 1'b0});
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {frame_ack_o, vec_valid_o, fetch_ack_o, wait_r} <= '0;
      vec_data_o <= 32'h5a5a_a5a5;
    end else begin
      wait_r      <= (open && !go) ? wait_r + 2'h1 : 2'h0;
      frame_ack_o <= go && frame_req_i;
      vec_valid_o <= go && vec_rd_i;
      fetch_ack_o <= go && fetch_req_i;
      vec_data_o  <= (go && vec_rd_i) ? HANDLER : ~vec_data_o;
    end
  end
endmodule : ifte_pipe_model

/* sim/ifte_core_assertions.sv */
// Purpose: Port level assertions for the exception unit.
// Assumes: Bound to every ifte_core instance.
// Notes:   Idle means no sequence running and no frame pending.
`timescale 1ns/1ps
module ifte_core_chk (
  // Clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  rstn_i,
  // Inputs of the unit
  input wire logic                  irq_pending_i,
  input wire logic                  frame_ack_i,
  input wire logic                  vec_valid_i,
  input wire logic [15:0]           status_word_i,
  input wire logic [31:0]           vec_data_i,
  input wire ifte_pkg::ifte_issue_t issue_i,
  // Outputs of the unit
  input wire logic                  sr_wr_o,
  input wire logic                  exec_block_o,
  input wire logic                  irq_hold_o,
  input wire logic                  busy_o,
  input wire logic                  frame_req_o,
  input wire logic                  vec_rd_o,
  input wire logic                  fetch_req_o,
  input wire logic [15:0]           sr_new_o,
  input wire logic [31:0]           fetch_addr_o,
  input wire ifte_pkg::ifte_frame_t frame_o
);
  import ifte_pkg::*;
  logic idle, aline, user;
  assign idle  = !busy_o && !frame_req_o;
  assign aline = issue_i.opword[15:12] == IFTE_ALINE;
  assign user  = !status_word_i[IFTE_SR_SUP];
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_block_exec: assert property (issue_i.valid && idle && (issue_i.illegal || aline ||
    issue_i.priv && user) |=> exec_block_o && sr_wr_o && frame_req_o)
    else $error("faulting instruction not blocked");
  a_sr_entry: assert property (sr_wr_o |-> sr_new_o[15:13] == 3'b001)
    else $error("new status word not supervisor without trace");
  a_vec_illegal: assert property (issue_i.valid && idle && issue_i.illegal && !aline
    |=> frame_o.vec == IFTE_VEC_ILLEGAL && frame_o.pc == $past(issue_i.pc))
    else $error("illegal instruction frame wrong");
  a_vec_aline: assert property (issue_i.valid && idle && aline
    |=> frame_o.vec == IFTE_VEC_UNIMPL && frame_o.pc == $past(issue_i.pc))
    else $error("unimplemented instruction frame wrong");
  a_vec_priv: assert property (issue_i.valid && idle && issue_i.priv && user &&
    !issue_i.illegal && !aline |=> frame_o.vec == IFTE_VEC_PRIV && frame_o.pc == $past(issue_i.pc))
    else $error("privilege violation frame wrong");
  a_priv_super: assert property (issue_i.valid && idle && issue_i.priv && !user &&
    !issue_i.illegal && !aline |=> !exec_block_o)
    else $error("privileged instruction blocked in supervisor mode");
  a_frame_offset: assert property (frame_req_o |-> frame_o.offset == {6'h0, frame_o.vec, 2'b00})
    else $error("vector offset does not match vector");
  a_frame_hold: assert property (frame_req_o && !frame_ack_i |=> frame_req_o && $stable(frame_o))
    else $error("frame dropped before acknowledge");
  a_fetch_target: assert property (vec_rd_o && vec_valid_i
    |=> fetch_req_o && fetch_addr_o == $past(vec_data_i))
    else $error("prefetch not from fetched vector");
  a_irq_defer: assert property (frame_req_o && frame_o.vec == IFTE_VEC_TRACE &&
    irq_pending_i && $past(irq_pending_i) |-> irq_hold_o)
    else $error("interrupt not held during trace");
endmodule : ifte_core_chk
bind ifte_core ifte_core_chk u_chk (.core_clk_i, .rstn_i, .irq_pending_i, .frame_ack_i,
  .vec_valid_i, .status_word_i, .vec_data_i, .issue_i, .sr_wr_o, .exec_block_o, .irq_hold_o,
  .busy_o, .frame_req_o, .vec_rd_o, .fetch_req_o, .sr_new_o, .fetch_addr_o, .frame_o);

/* sim/test_instr_fault_trace_exceptions.sv */
// Purpose: Self-checking bench for the fault and trace exception unit.
// Assumes: The pipeline model answers frame, vector and prefetch requests.
// Notes:   The trace mode cases clear the status word after issue, so the sampled field decides.
`timescale 1ns/1ps
module test_instr_fault_trace_exceptions;
  import ifte_pkg::*;
  localparam logic [31:0] HND = 32'h0000_2000;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
  logic suspend_i = 1'b0, irq_pending_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, vbase = 32'h0, rv, npc;
  logic [15:0] status_word_i = 16'h0, sr_new_o;
  ifte_issue_t issue_i = '0;
  ifte_done_t done_i = '0;
  ifte_frame_t frame_o;
  logic [31:0] reg_rdata_o, vec_addr_o, vec_data_i, fetch_addr_o;
  logic sr_wr_o, exec_block_o, stop_inhibit_o, irq_hold_o, busy_o, frame_req_o, frame_ack_i;
  logic vec_rd_o, vec_valid_i, fetch_req_o, fetch_ack_i;
  logic [4:0] tcase [6] = '{5'b10001, 5'b01111, 5'b01100, 5'b01000, 5'b00110, 5'b11110};
  int n_fail = 0, cmp_count = 0, cyc = 0;
  always #4 core_clk_i = ~core_clk_i;
  ifte_core uut (.core_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .issue_i, .done_i, .suspend_i, .irq_pending_i, .status_word_i, .sr_wr_o,
    .sr_new_o, .exec_block_o, .stop_inhibit_o, .irq_hold_o, .busy_o, .frame_req_o, .frame_o,
    .frame_ack_i, .vec_rd_o, .vec_addr_o, .vec_valid_i, .vec_data_i, .fetch_req_o,
    .fetch_addr_o, .fetch_ack_i);
  ifte_pipe_model #(.HANDLER(HND)) u_pipe (.clk_i(core_clk_i), .rstn_i, .slow_i(slow),
    .frame_req_i(frame_req_o), .vec_rd_i(vec_rd_o), .fetch_req_i(fetch_req_o),
    .frame_ack_o(frame_ack_i), .vec_valid_o(vec_valid_i), .fetch_ack_o(fetch_ack_i),
    .vec_data_o(vec_data_i));
  // ========
  // Tasks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd
  // Kind bits are illegal, privileged, flow class and stop.
  task automatic iss(input logic [15:0] sw, op, input logic [31:0] pc, input logic [3:0] kind);
    @(posedge core_clk_i);
    status_word_i <= sw;
    issue_i       <= {1'b1, op, pc, kind};
    @(posedge core_clk_i);
    issue_i.valid <= 1'b0;
    #1;
  endtask : iss
  task automatic fin(input logic [31:0] pc, input logic tk, fc, input logic [7:0] fv);
    @(posedge core_clk_i);
    done_i <= {1'b1, pc, tk, fc, fv, pc};
    @(posedge core_clk_i);
    done_i.valid <= 1'b0;
    #1;
  endtask : fin
  task automatic frame(input logic [7:0] v, input logic [31:0] pc, input logic [15:0] sr,
                       input logic blk);
    int k;
    logic [31:0] va, fa;
    va = 32'h0;
    fa = 32'h0;
    for (k = 0; k < 8 && frame_req_o !== 1'b1; k++) @(posedge core_clk_i) #1;
    chk("frame request", 32'h1, {31'h0, frame_req_o});
    chk("block", {31'h0, blk}, {31'h0, exec_block_o});
    chk("status load", 32'h1, {31'h0, sr_wr_o});
    chk("new status", {16'h0, 3'b001, sr[12:0]}, {16'h0, sr_new_o});
    chk("vector", {24'h0, v}, {24'h0, frame_o.vec});
    chk("offset", {22'h0, v, 2'b00}, {16'h0, frame_o.offset});
    chk("saved pc", pc, frame_o.pc);
    chk("saved status", {16'h0, sr}, {16'h0, frame_o.sr});
    if (v == IFTE_VEC_TRACE) chk("irq hold", {31'h0, irq_pending_i}, {31'h0, irq_hold_o});
    for (k = 0; k < 40 && (frame_req_o || vec_rd_o || fetch_req_o); k++) begin
      @(posedge core_clk_i) #1;
      if (vec_rd_o) va = vec_addr_o;
      if (fetch_req_o) fa = fetch_addr_o;
    end
    chk("vector address", vbase + {22'h0, v, 2'b00}, va);
    chk("prefetch address", HND, fa);
  endtask : frame
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge core_clk_i) #1;
      chk("no exception", 32'h0, {29'h0, busy_o, frame_req_o, exec_block_o});
    end
  endtask : quiet
  // ========
  // Sequence
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    reg_rd(IFTE_OFS_VBASE, rv);
    chk("base reset", IFTE_VBASE_RST, rv);
    vbase = 32'h0000_1000;
    reg_wr(IFTE_OFS_VBASE, vbase);
    reg_wr(IFTE_OFS_PC, 32'hffff_ffff);
    reg_rd(IFTE_OFS_VBASE, rv);
    chk("base", vbase, rv);
    reg_rd(IFTE_OFS_PC, rv);
    chk("read only pc", 32'h0, rv);
    reg_rd(4'h2, rv);
    chk("unmapped", 32'h0, rv);
    $display("test registers done");
    iss(16'h8000, 16'h4afc, 32'h100, 4'b1000);
    frame(IFTE_VEC_ILLEGAL, 32'h100, 16'h8000, 1'b1);
    fin(32'h102, 1'b0, 1'b0, 8'h00);
    quiet(4);
    reg_rd(IFTE_OFS_PC, rv);
    chk("last pc", 32'h100, rv);
    slow = 1'b1;
    iss(16'h0000, 16'ha123, 32'h200, 4'b0100);
    frame(IFTE_VEC_UNIMPL, 32'h200, 16'h0000, 1'b1);
    iss(16'h0700, 16'h46fc, 32'h300, 4'b0100);
    frame(IFTE_VEC_PRIV, 32'h300, 16'h0700, 1'b1);
    iss(16'h2000, 16'h46fc, 32'h400, 4'b0100);
    quiet(3);
    fin(32'h404, 1'b1, 1'b0, 8'h00);
    quiet(3);
    $display("test faults done");
    for (int i = 0; i < 6; i++) begin
      slow = i[0];
      npc = 32'h600 + 32'(i * 8);
      iss({tcase[i][4:3], 14'h0}, 16'h4e71, npc - 32'h2, {2'b00, tcase[i][2], 1'b0});
      status_word_i <= 16'h0;
      fin(npc, tcase[i][1], 1'b0, 8'h00);
      if (tcase[i][0]) frame(IFTE_VEC_TRACE, npc, 16'h0, 1'b0);
      else quiet(4);
    end
    $display("test trace modes done");
    iss(16'he000, 16'h4e72, 32'h700, 4'b0111);
    chk("stop inhibit", 32'h1, {31'h0, stop_inhibit_o});
    fin(32'h704, 1'b1, 1'b0, 8'h00);
    frame(IFTE_VEC_TRACE, 32'h704, 16'he000, 1'b0);
    chk("stop inhibit end", 32'h0, {31'h0, stop_inhibit_o});
    irq_pending_i <= 1'b1;
    iss(16'h8000, 16'h80fc, 32'h800, 4'b0000);
    fin(32'h804, 1'b0, 1'b1, 8'h05);
    frame(8'h05, 32'h804, 16'h8000, 1'b0);
    chk("trace owed", 32'h1, {31'h0, busy_o});
    frame(IFTE_VEC_TRACE, 32'h804, 16'h8000, 1'b0);
    irq_pending_i <= 1'b0;
    $display("test stop and ordering done");
    iss(16'h8000, 16'h2010, 32'h900, 4'b0000);
    @(posedge core_clk_i);
    suspend_i <= 1'b1;
    @(posedge core_clk_i);
    suspend_i <= 1'b0;
    quiet(4);
    fin(32'h902, 1'b0, 1'b0, 8'h00);
    frame(IFTE_VEC_TRACE, 32'h902, 16'h8000, 1'b0);
    reg_rd(IFTE_OFS_COUNT, rv);
    chk("exception count", 32'h0000_0009, rv);
    reg_rd(IFTE_OFS_INFO, rv);
    chk("last info", 32'h8000_0009, rv);
    $display("test suspend done");
    end_sim();
  end
endmodule : test_instr_fault_trace_exceptions
